// ==== hdl/aigo_defs.vh ====
/*
 * Register map, field positions and reset values of the input, gain and
 * offset register bank.
 * Assumes inclusion by bare name from the design files of this block.
 */
`ifndef AIGO_DEFS_VH
`define AIGO_DEFS_VH

// Register indices; the byte address on the bus is four times the index.
`define AIGO_IDX_INPUT_CONFIG      8'h05
`define AIGO_IDX_RED_GAIN          8'h06
`define AIGO_IDX_GREEN_GAIN        8'h07
`define AIGO_IDX_BLUE_GAIN         8'h08
`define AIGO_IDX_RED_OFFSET        8'h09
`define AIGO_IDX_GREEN_OFFSET      8'h0A
`define AIGO_IDX_BLUE_OFFSET       8'h0B
`define AIGO_IDX_OFFSET_DAC_CONFIG 8'h0C

// Reset values.
`define AIGO_RST_INPUT_CONFIG      8'h00
`define AIGO_RST_GAIN              8'h55
`define AIGO_RST_OFFSET            8'h80
`define AIGO_RST_OFFSET_DAC_CONFIG 8'h00

// Input configuration fields.
`define AIGO_IC_CHANNEL_SEL 0
`define AIGO_IC_COUPLING    1
`define AIGO_IC_COLOR_SPACE 2
`define AIGO_IC_SYNC_TYPE   3
`define AIGO_IC_CSYNC_SRC   4
`define AIGO_IC_COAST_CLAMP 5

// Offset DAC configuration fields.
`define AIGO_OD_RANGE     0
`define AIGO_OD_RED_LSB   2
`define AIGO_OD_GREEN_LSB 4
`define AIGO_OD_BLUE_LSB  6

// Writable bit masks; reserved bits read as zero.
`define AIGO_MASK_INPUT_CONFIG      8'h3F
`define AIGO_MASK_OFFSET_DAC_CONFIG 8'hFD

// Offset code that means zero digital offset.
`define AIGO_OFFSET_MID 8'h80

// Clamp level codes and black level targets.
`define AIGO_CLAMP_300MV 1'b0
`define AIGO_CLAMP_600MV 1'b1
`define AIGO_BLACK_ZERO  8'h00
`define AIGO_BLACK_MID   8'h80

`endif

// ==== hdl/aigo_channel.v ====
/*
 * Per-channel offset and gain path: digital offset, 10-bit analog offset
 * DAC word and gain code, all registered.
 * Assumes one system clock and a synchronous active-high reset.
 */
`timescale 1ns/100ps
`include "aigo_defs.vh"

module aigo_channel (
  input  wire       clk,
  input  wire       rst,
  input  wire [7:0] gain_code,
  input  wire [7:0] offset_code,
  input  wire [1:0] dac_lsb,
  input  wire       comp_enable,
  output reg  [7:0] gain_out_reg,
  output reg  [8:0] digital_offset_reg,
  output reg  [9:0] dac_word_reg
);

  wire [8:0] offset_ext;
  wire [8:0] mid_ext;

  assign offset_ext = {1'b0, offset_code};
  assign mid_ext    = {1'b0, `AIGO_OFFSET_MID};

  // Digital offset is the code minus mid; analog word is held at mid while the
  // digital path is active so the DAC stays centred.
  always @(posedge clk) begin
    if (rst) begin
      gain_out_reg       <= `AIGO_RST_GAIN;
      digital_offset_reg <= 9'h000;
      dac_word_reg       <= 10'h200;
    end else begin
      gain_out_reg <= gain_code;
      if (comp_enable) begin
        digital_offset_reg <= offset_ext - mid_ext;
        dac_word_reg       <= 10'h200;
      end else begin
        digital_offset_reg <= 9'h000;
        dac_word_reg       <= {offset_code, dac_lsb};
      end
    end
  end

endmodule

// ==== hdl/aigo_regs.v ====
/*
 * Input configuration, gain and offset register bank with an APB slave,
 * and the control outputs that these registers steer: input selection,
 * clamp switches, colour-space clamp levels and black-level targets, sync
 * steering, and per-channel gain, digital offset and offset DAC words.
 * Assumes APB masters on the same clock as SYS_CLK and a synchronous,
 * active-high SYS_RST held for at least two edges so the synchronisers
 * flush; analog status inputs (clamp interval, holdover, compensation
 * enable, sync pins) come from other clocks and are synchronised here.
 * Assumes the per-channel datapath module and the shared definitions header.
 */
`timescale 1ns/100ps
`include "aigo_defs.vh"

// Overview of operation
// - When AC coupled, the negative input is tied to the clamp DAC and the positive input only during clamping.
// - When DC coupled, no input reaches a clamp DAC and the analog clamp is held off.
// - In RGB mode all channels clamp at 300 mV with half-scale shift and black target 0x00.
// - In YUV mode red and blue clamp at 600 mV with target 0x80, green at 300 mV with shift and target 0x00.
// - Bit 3 of input configuration picks separate sync at zero and composite sync at one.
// - Bit 4 picks sync-on-green at zero or the horizontal sync input at one, and separate sync always passes horizontal sync.
// - During holdover, clamping and black-level compensation stop when bit 5 is zero and continue when it is one.
// - Each 8-bit gain code sets the gain to 0.5 plus code over 170, with 0x55 at reset.
// - With compensation enabled the offset register is a digital offset of one output code per step.
// - The digital offset equals the offset code minus 0x80.
// - With compensation disabled the offset code forms the upper eight bits of the 10-bit offset DAC.
// - The two low DAC bits come from offset DAC configuration bits 3:2, 5:4 and 7:6 for red, green and blue.
// - Bit 0 of offset DAC configuration selects half or quarter of full scale as DAC range.
module aigo_regs (
  input  wire        SYS_CLK,
  input  wire        SYS_RST,
  input  wire        PSEL,
  input  wire        PENABLE,
  input  wire        PWRITE,
  input  wire [31:0] PADDR,
  input  wire [31:0] PWDATA,
  output reg  [31:0] PRDATA,
  output reg         PREADY,
  output reg         PSLVERR,
  input  wire        CLAMP_WINDOW,
  input  wire        COAST_ACTIVE,
  input  wire        COMP_ENABLE,
  input  wire        HSYNC_IN,
  input  wire        SYNC_ON_GREEN_IN,
  output reg         INPUT_SET_SECOND,
  output reg         NEG_TO_CLAMP_DAC,
  output reg         POS_TO_CLAMP_DAC,
  output reg         ANALOG_CLAMP_ON,
  output reg  [2:0]  CLAMP_600MV,
  output reg  [2:0]  HALF_SCALE_SHIFT,
  output reg  [23:0] BLACK_TARGET,
  output reg         SYNC_COMPOSITE,
  output reg         SYNC_MUX_OUT,
  output reg         COMP_RUN,
  output reg  [23:0] GAIN_CODE,
  output reg  [26:0] DIGITAL_OFFSET,
  output reg  [29:0] OFFSET_DAC_WORD,
  output reg         OFFSET_DAC_QUARTER
);

  // Register storage; reserved bits are never stored.
  reg  [7:0]  input_config_reg;
  reg  [7:0]  gain_reg [0:2];
  reg  [7:0]  offset_reg [0:2];
  reg  [7:0]  offset_dac_config_reg;
  // Read decode results, settled before the first access edge.
  reg  [7:0]  rdata_next;
  reg         addr_hit_next;
  // Synchroniser stages for the asynchronous status inputs.
  reg  [4:0]  sync_a_reg;
  reg  [4:0]  sync_b_reg;
  // Bus phase decode.
  wire [7:0]  word_index;
  wire        access;
  wire        write_take;
  // Synchronised status levels.
  wire        clamp_s;
  wire        coast_s;
  wire        comp_s;
  wire        hsync_s;
  wire        sog_s;
  // Decoded configuration.
  wire        dc_coupled;
  wire        yuv;
  wire        clamp_allowed;
  wire        clamp_gate;
  // Per-channel results, packed {blue, green, red}.
  wire [23:0] gain_ch;
  wire [26:0] dofs_ch;
  wire [29:0] dac_ch;

  // Bus phase decode. A write is taken only at the edge that completes the
  // access phase, so the wait-state cycle never writes; a request held past completion writes again two edges later.
  assign word_index = PADDR[9:2];
  assign access     = PSEL & PENABLE;
  assign write_take = access & PREADY & PWRITE & addr_hit_next;

  // Two-stage synchronisers for every asynchronous status input; only the
  // second stage is read by logic. Each level is synchronised on its own, so
  // two inputs that change together may be seen one edge apart; none of the
  // decisions below depends on two of them changing in the same cycle.
  always @(posedge SYS_CLK) begin
    if (SYS_RST) begin
      sync_a_reg <= 5'h00;
      sync_b_reg <= 5'h00;
    end else begin
      sync_a_reg <= {SYNC_ON_GREEN_IN, HSYNC_IN, COMP_ENABLE, COAST_ACTIVE, CLAMP_WINDOW};
      sync_b_reg <= sync_a_reg;
    end
  end

  assign clamp_s = sync_b_reg[0];
  assign coast_s = sync_b_reg[1];
  assign comp_s  = sync_b_reg[2];
  assign hsync_s = sync_b_reg[3];
  assign sog_s   = sync_b_reg[4];

  // Read decode; unaligned or unmapped addresses read zero and flag an error.
  // Only the low ten address bits select a word; anything set above them is
  // treated as unmapped rather than aliased, so a stray pointer cannot reach
  // a live register.
  always @* begin
    rdata_next    = 8'h00;
    addr_hit_next = 1'b1;
    if (PADDR[1:0] != 2'h0 || PADDR[31:10] != 22'h000000) begin
      addr_hit_next = 1'b0;
    end else if (word_index == `AIGO_IDX_INPUT_CONFIG) begin
      rdata_next = input_config_reg;
    end else if (word_index == `AIGO_IDX_RED_GAIN) begin
      rdata_next = gain_reg[0];
    end else if (word_index == `AIGO_IDX_GREEN_GAIN) begin
      rdata_next = gain_reg[1];
    end else if (word_index == `AIGO_IDX_BLUE_GAIN) begin
      rdata_next = gain_reg[2];
    end else if (word_index == `AIGO_IDX_RED_OFFSET) begin
      rdata_next = offset_reg[0];
    end else if (word_index == `AIGO_IDX_GREEN_OFFSET) begin
      rdata_next = offset_reg[1];
    end else if (word_index == `AIGO_IDX_BLUE_OFFSET) begin
      rdata_next = offset_reg[2];
    end else if (word_index == `AIGO_IDX_OFFSET_DAC_CONFIG) begin
      rdata_next = offset_dac_config_reg;
    end else begin
      addr_hit_next = 1'b0;
    end
  end

  // APB handshake: one wait state, so PREADY rises in the second access cycle
  // and falls again right after the completing edge. Read data is captured in
  // the first access cycle and held for the one cycle that PREADY stands; the
  // extra cycle buys a registered PRDATA at the cost of one clock per access.
  always @(posedge SYS_CLK) begin
    if (SYS_RST) begin
      PREADY  <= 1'b0;
      PRDATA  <= 32'h00000000;
      PSLVERR <= 1'b0;
    end else if (access && !PREADY) begin
      PREADY  <= 1'b1;
      PRDATA  <= PWRITE ? 32'h00000000 : {24'h000000, rdata_next};
      PSLVERR <= ~addr_hit_next;
    end else begin
      PREADY  <= 1'b0;
      PRDATA  <= 32'h00000000;
      PSLVERR <= 1'b0;
    end
  end

  // Writes land at the completing edge; reserved bits are masked so they
  // always read back as zero whatever software writes. Masking here keeps
  // the steering logic free of modes that no setting defines.
  always @(posedge SYS_CLK) begin
    if (SYS_RST) begin
      input_config_reg      <= `AIGO_RST_INPUT_CONFIG;
      offset_dac_config_reg <= `AIGO_RST_OFFSET_DAC_CONFIG;
    end else if (write_take) begin
      if (word_index == `AIGO_IDX_INPUT_CONFIG) begin
        input_config_reg <= PWDATA[7:0] & `AIGO_MASK_INPUT_CONFIG;
      end else if (word_index == `AIGO_IDX_OFFSET_DAC_CONFIG) begin
        offset_dac_config_reg <= PWDATA[7:0] & `AIGO_MASK_OFFSET_DAC_CONFIG;
      end
    end
  end

  // Per-channel gain and offset storage with its write decode, and the
  // channel datapath behind it. Each channel process writes only its own
  // entries, so no storage word has more than one writer.
  // Channel 0 is red, 1 green and 2 blue throughout.
  genvar ch;
  generate
    for (ch = 0; ch < 3; ch = ch + 1) begin : g_store
      always @(posedge SYS_CLK) begin
        if (SYS_RST) begin
          gain_reg[ch]   <= `AIGO_RST_GAIN;
          offset_reg[ch] <= `AIGO_RST_OFFSET;
        end else if (write_take) begin
          if (word_index == `AIGO_IDX_RED_GAIN + ch) begin
            gain_reg[ch] <= PWDATA[7:0];
          end else if (word_index == `AIGO_IDX_RED_OFFSET + ch) begin
            offset_reg[ch] <= PWDATA[7:0];
          end
        end
      end

      // The channel registers its results once more, so a register write
      // reaches the data outputs two edges after it lands; the lag is the
      // same for all three channels, so they never disagree for a cycle.
      aigo_channel u_channel (
        .clk                (SYS_CLK),
        .rst                (SYS_RST),
        .gain_code          (gain_reg[ch]),
        .offset_code        (offset_reg[ch]),
        .dac_lsb            (offset_dac_config_reg[`AIGO_OD_RED_LSB + 2 * ch +: 2]),
        .comp_enable        (comp_s),
        .gain_out_reg       (gain_ch[8 * ch +: 8]),
        .digital_offset_reg (dofs_ch[9 * ch +: 9]),
        .dac_word_reg       (dac_ch[10 * ch +: 10])
      );
    end
  endgenerate

  // Decoded configuration. Clamping is gated during holdover unless the
  // coast clamp bit keeps it running; DC coupling gates it off altogether.
  // One shared gate keeps the positive switch and the clamp signal in step.
  assign dc_coupled    = input_config_reg[`AIGO_IC_COUPLING];
  assign yuv           = input_config_reg[`AIGO_IC_COLOR_SPACE];
  assign clamp_allowed = ~coast_s | input_config_reg[`AIGO_IC_COAST_CLAMP];
  assign clamp_gate    = ~dc_coupled & clamp_s & clamp_allowed;

  // Input selection and clamp switches. The negative input stays on its clamp
  // DAC whenever AC coupled; the positive input joins it only in the clamp
  // window, and the analog clamp signal follows the positive switch.
  // All switches open during reset; the reset setting is AC coupled, so the negative input joins its clamp DAC at the first edge after it.
  always @(posedge SYS_CLK) begin
    if (SYS_RST) begin
      INPUT_SET_SECOND <= 1'b0;
      NEG_TO_CLAMP_DAC <= 1'b0;
      POS_TO_CLAMP_DAC <= 1'b0;
      ANALOG_CLAMP_ON  <= 1'b0;
    end else begin
      INPUT_SET_SECOND <= input_config_reg[`AIGO_IC_CHANNEL_SEL];
      NEG_TO_CLAMP_DAC <= ~dc_coupled;
      POS_TO_CLAMP_DAC <= clamp_gate;
      ANALOG_CLAMP_ON  <= clamp_gate;
    end
  end

  // Colour-space presets, packed {blue, green, red}. In YUV the chroma
  // channels sit at mid code, so only green keeps the half-scale shift.
  // The presets follow the mode bit one edge later; nothing is latched.
  always @(posedge SYS_CLK) begin
    if (SYS_RST) begin
      CLAMP_600MV      <= 3'h0;
      HALF_SCALE_SHIFT <= 3'h0;
      BLACK_TARGET     <= 24'h000000;
    end else if (yuv) begin
      CLAMP_600MV      <= {`AIGO_CLAMP_600MV, `AIGO_CLAMP_300MV, `AIGO_CLAMP_600MV};
      HALF_SCALE_SHIFT <= 3'h2;
      BLACK_TARGET     <= {`AIGO_BLACK_MID, `AIGO_BLACK_ZERO, `AIGO_BLACK_MID};
    end else begin
      CLAMP_600MV      <= {3{`AIGO_CLAMP_300MV}};
      HALF_SCALE_SHIFT <= 3'h7;
      BLACK_TARGET     <= {3{`AIGO_BLACK_ZERO}};
    end
  end

  // Sync steering and compensation run flag. Separate sync always passes the
  // horizontal sync input, whatever the composite source bit says, so a stale
  // source setting cannot disturb a separate-sync source.
  always @(posedge SYS_CLK) begin
    if (SYS_RST) begin
      SYNC_COMPOSITE <= 1'b0;
      SYNC_MUX_OUT   <= 1'b0;
      COMP_RUN       <= 1'b0;
    end else begin
      SYNC_COMPOSITE <= input_config_reg[`AIGO_IC_SYNC_TYPE];
      COMP_RUN       <= comp_s & clamp_allowed;
      if (input_config_reg[`AIGO_IC_SYNC_TYPE] && !input_config_reg[`AIGO_IC_CSYNC_SRC]) begin
        SYNC_MUX_OUT <= sog_s;
      end else begin
        SYNC_MUX_OUT <= hsync_s;
      end
    end
  end

  // Per-channel data words, packed {blue, green, red}. This register stage
  // keeps every top-level output straight from a flip-flop, at the cost of
  // one more edge of latency on the data words; the words read zero during
  // reset and reach their defaults at the first edge after it.
  always @(posedge SYS_CLK) begin
    if (SYS_RST) begin
      GAIN_CODE          <= 24'h000000;
      DIGITAL_OFFSET     <= 27'h0000000;
      OFFSET_DAC_WORD    <= 30'h00000000;
      OFFSET_DAC_QUARTER <= 1'b0;
    end else begin
      GAIN_CODE          <= gain_ch;
      DIGITAL_OFFSET     <= dofs_ch;
      OFFSET_DAC_WORD    <= dac_ch;
      OFFSET_DAC_QUARTER <= offset_dac_config_reg[`AIGO_OD_RANGE];
    end
  end

endmodule

// ==== sim/aigo_props.sv ====
/*
 * Concurrent checks on the ports of the input, gain and offset register bank.
 * Assumes binding into aigo_regs with one clock and synchronous active-high reset.
 */
`timescale 1ns/100ps
module aigo_props (
  input wire        SYS_CLK,
  input wire        SYS_RST,
  input wire        PSEL,
  input wire        PENABLE,
  input wire        PWRITE,
  input wire [31:0] PADDR,
  input wire [31:0] PWDATA,
  input wire [31:0] PRDATA,
  input wire        PREADY,
  input wire        PSLVERR,
  input wire        NEG_TO_CLAMP_DAC,
  input wire        POS_TO_CLAMP_DAC,
  input wire        ANALOG_CLAMP_ON,
  input wire [2:0]  CLAMP_600MV,
  input wire [2:0]  HALF_SCALE_SHIFT,
  input wire [23:0] BLACK_TARGET,
  input wire        SYNC_COMPOSITE,
  input wire        INPUT_SET_SECOND,
  input wire [23:0] GAIN_CODE,
  input wire [26:0] DIGITAL_OFFSET,
  input wire [29:0] OFFSET_DAC_WORD,
  input wire        OFFSET_DAC_QUARTER
);
  // All checks share the one clock; reset silences them.
  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (SYS_RST);
  // A write taken by the slave at this edge.
  wire acc_wr = PSEL && PENABLE && PREADY && PWRITE;

  AST_CLAMP_MIRROR: assert property (ANALOG_CLAMP_ON == POS_TO_CLAMP_DAC)
    else $error("analog clamp differs from clamp switch");
  AST_DC_OPEN: assert property (!NEG_TO_CLAMP_DAC |-> !POS_TO_CLAMP_DAC)
    else $error("positive input clamped while dc coupled");
  AST_YUV_SET: assert property (CLAMP_600MV == 3'h5 |-> HALF_SCALE_SHIFT == 3'h2 && BLACK_TARGET == 24'h800080)
    else $error("yuv shift or black target wrong");
  AST_RGB_SET: assert property (!$past(SYS_RST) && CLAMP_600MV == 3'h0 |-> HALF_SCALE_SHIFT == 3'h7 && BLACK_TARGET == 24'h0)
    else $error("rgb shift or black target wrong");
  AST_CLAMP_CODE: assert property (CLAMP_600MV == 3'h0 || CLAMP_600MV == 3'h5)
    else $error("clamp level pattern illegal");
  AST_ERR_ZERO: assert property (PREADY && PSLVERR |-> PRDATA == 32'h0)
    else $error("error answer carries data");
  AST_SYNC_TYPE: assert property (acc_wr && PADDR == 32'h14 |-> ##2
    SYNC_COMPOSITE == $past(PWDATA[3], 2) && INPUT_SET_SECOND == $past(PWDATA[0], 2))
    else $error("sync type or channel select not applied");
  AST_RANGE: assert property (acc_wr && PADDR == 32'h30 |-> ##2 OFFSET_DAC_QUARTER == $past(PWDATA[0], 2))
    else $error("dac range not applied");
  AST_GAIN: assert property (acc_wr && PADDR == 32'h18 |-> ##3 GAIN_CODE[7:0] == $past(PWDATA[7:0], 3))
    else $error("red gain not applied");
  AST_DAC_HOLD: assert property (DIGITAL_OFFSET != 27'h0 |-> OFFSET_DAC_WORD == 30'h20080200)
    else $error("dac not held mid while digital offset active");

  C_ERR: cover property (PREADY && PSLVERR);
  C_YUV: cover property (CLAMP_600MV == 3'h5);
  C_DOFS: cover property (DIGITAL_OFFSET != 27'h0);
endmodule
bind aigo_regs aigo_props u_props (.SYS_CLK(SYS_CLK), .SYS_RST(SYS_RST), .PSEL(PSEL), .PENABLE(PENABLE),
  .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
  .NEG_TO_CLAMP_DAC(NEG_TO_CLAMP_DAC), .POS_TO_CLAMP_DAC(POS_TO_CLAMP_DAC), .ANALOG_CLAMP_ON(ANALOG_CLAMP_ON),
  .CLAMP_600MV(CLAMP_600MV), .HALF_SCALE_SHIFT(HALF_SCALE_SHIFT), .BLACK_TARGET(BLACK_TARGET),
  .SYNC_COMPOSITE(SYNC_COMPOSITE), .INPUT_SET_SECOND(INPUT_SET_SECOND), .GAIN_CODE(GAIN_CODE),
  .DIGITAL_OFFSET(DIGITAL_OFFSET), .OFFSET_DAC_WORD(OFFSET_DAC_WORD), .OFFSET_DAC_QUARTER(OFFSET_DAC_QUARTER));

// ==== sim/test_afe_input_gain_offset_regs.sv ====
/*
 * Self-checking bench for the input, gain and offset register bank over APB.
 * Assumes the checker is bound separately and a 100 ns system clock.
 */
`timescale 1ns/100ps
module test_afe_input_gain_offset_regs;
  reg         clk, rst, psel, pen, pwr, clamp_win, coast, comp, hs, sync_on_green_input, err;
  reg  [31:0] paddr, pwdata, rd;
  wire [31:0] prdata;
  wire        pready, pslverr, set2, neg, pos, aclamp, csync, mux, crun, quarter;
  wire [2:0]  c600, shift;
  wire [23:0] black, gain;
  wire [26:0] dofs;
  wire [29:0] dac;
  integer     num_errors, total_checks, i;

  aigo_regs u_dut (.SYS_CLK(clk), .SYS_RST(rst), .PSEL(psel), .PENABLE(pen), .PWRITE(pwr), .PADDR(paddr),
    .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr), .CLAMP_WINDOW(clamp_win),
    .COAST_ACTIVE(coast), .COMP_ENABLE(comp), .HSYNC_IN(hs), .SYNC_ON_GREEN_IN(sync_on_green_input), .INPUT_SET_SECOND(set2),
    .NEG_TO_CLAMP_DAC(neg), .POS_TO_CLAMP_DAC(pos), .ANALOG_CLAMP_ON(aclamp), .CLAMP_600MV(c600),
    .HALF_SCALE_SHIFT(shift), .BLACK_TARGET(black), .SYNC_COMPOSITE(csync), .SYNC_MUX_OUT(mux),
    .COMP_RUN(crun), .GAIN_CODE(gain), .DIGITAL_OFFSET(dofs), .OFFSET_DAC_WORD(dac), .OFFSET_DAC_QUARTER(quarter));

  // Prints the counts and the verdict, then stops the run.
  task results;
    begin
      $display("checks %0d errors %0d", total_checks, num_errors);
      if (num_errors == 0 && total_checks > 0) begin
        $display("All tests passed");
      end else begin
        $display("Some tests failed");
      end
      $finish;
    end
  endtask

  task chk(input [95:0] nm, input [31:0] exp, input [31:0] got);
    begin
      total_checks = total_checks + 1;
      if (got !== exp) begin
        num_errors = num_errors + 1;
        $display("MISMATCH %0s expected %h seen %h", nm, exp, got);
      end
    end
  endtask

  // One APB transfer; the wait for pready is bounded so a dead slave ends the run.
  task apb(input w, input [31:0] a, input [31:0] d);
    integer n;
    begin
      @(posedge clk);
      psel <= 1'b1; pwr <= w; paddr <= a; pwdata <= d;
      @(posedge clk);
      pen <= 1'b1;
      n = 0;
      @(posedge clk);
      while (pready !== 1'b1 && n < 16) begin
        @(posedge clk);
        n = n + 1;
      end
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      pen <= 1'b0;
      if (n == 16) begin
        num_errors = num_errors + 1;
        $display("MISMATCH pready expected 1 seen 0");
        results;
      end
    end
  endtask

  task rchk(input [31:0] a, input [31:0] exp, input e);
    begin
      apb(1'b0, a, 32'h0);
      chk("rdata", exp, rd);
      chk("slverr", {31'h0, e}, {31'h0, err});
    end
  endtask

  // Outputs lag by the synchronisers plus the output registers.
  task cfg(input [31:0] v);
    begin
      apb(1'b1, 32'h14, v);
      repeat (6) @(posedge clk);
    end
  endtask

  // Free-running system clock.
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  // Main sequence.
  initial begin
    num_errors = 0; total_checks = 0; rst = 1'b1; psel = 1'b0; pen = 1'b0; pwr = 1'b0; paddr = 32'h0;
    pwdata = 32'h0; clamp_win = 1'b1; coast = 1'b0; comp = 1'b0; hs = 1'b1; sync_on_green_input = 1'b0;
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    for (i = 5; i < 13; i = i + 1) rchk(i * 4, (i == 5 || i == 12) ? 32'h0 : (i < 9 ? 32'h55 : 32'h80), 1'b0);
    for (i = 5; i < 13; i = i + 1) apb(1'b1, i * 4, 32'hFF);
    for (i = 5; i < 13; i = i + 1) rchk(i * 4, i == 5 ? 32'h3F : (i == 12 ? 32'hFD : 32'hFF), 1'b0);
    apb(1'b1, 32'h19, 32'h00);
    rchk(32'h18, 32'hFF, 1'b0);
    rchk(32'h19, 32'h0, 1'b1);
    rchk(32'h34, 32'h0, 1'b1);
    rchk(32'h10, 32'h0, 1'b1);
    cfg(32'h00);
    chk("neg", 1, neg);
    chk("pos", 1, pos);
    chk("shift", 7, shift);
    chk("black", 0, black);
    chk("c600", 0, c600);
    coast <= 1'b1;
    cfg(32'h00);
    chk("pos", 0, pos);
    cfg(32'h20);
    chk("pos", 1, pos);
    clamp_win <= 1'b0;
    cfg(32'h20);
    chk("pos", 0, pos);
    clamp_win <= 1'b1;
    cfg(32'h22);
    chk("neg", 0, neg);
    chk("aclamp", 0, aclamp);
    comp <= 1'b1;
    cfg(32'h04);
    chk("c600", 5, c600);
    chk("shift", 2, shift);
    chk("black", 24'h800080, black);
    chk("crun", 0, crun);
    cfg(32'h24);
    chk("crun", 1, crun);
    hs <= 1'b0;
    sync_on_green_input <= 1'b1;
    cfg(32'h01);
    chk("mux", 0, mux);
    chk("set2", 1, set2);
    cfg(32'h10);
    chk("mux", 0, mux);
    cfg(32'h08);
    chk("mux", 1, mux);
    chk("csync", 1, csync);
    cfg(32'h18);
    chk("mux", 0, mux);
    apb(1'b1, 32'h18, 32'h00); apb(1'b1, 32'h1C, 32'hFF); apb(1'b1, 32'h20, 32'h55);
    apb(1'b1, 32'h24, 32'h00); apb(1'b1, 32'h28, 32'h80); apb(1'b1, 32'h2C, 32'hFF);
    apb(1'b1, 32'h30, 32'hE5);
    cfg(32'h00);
    chk("gain", 24'h55FF00, gain);
    chk("dofs", 27'h1FC0180, dofs);
    chk("dac", 30'h20080200, dac);
    chk("quarter", 1, quarter);
    comp <= 1'b0;
    cfg(32'h00);
    chk("dofs", 0, dofs);
    chk("dac", 30'h3FF80801, dac);
    results;
  end
endmodule
